// ==== fcs_checker.sv ====
// Port level assertions for the clock source mode control
module fcs_checker
  import fcs_pkg::*;
(
  // Clock, reset and control
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire fcs_pkg::fcs_ctrl_t ctrl_i,
  input wire logic debug_mode_i,
  input wire logic stop_i,
  // Clock outputs
  input wire logic output_clock_o,
  input wire logic debug_clock_o,
  input wire logic local_debug_clock_o,
  input wire logic internal_reference_clock_out_o,
  input wire logic external_reference_clock_out_o,
  // Loop, oscillator and status
  input wire logic fll_enable_o,
  input wire logic fll_ref_internal_o,
  input wire logic fll_ref_clk_o,
  input wire logic [fcs_pkg::TRIM_W-1:0] trim_o,
  input wire fcs_pkg::fcs_osc_t osc_o,
  input wire fcs_pkg::fcs_mode_t mode_o,
  input wire logic switch_pending_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // ---------------------------------------------------------------
  // Sequences and assertions
  // ---------------------------------------------------------------
  sequence s_stop_held;
    stop_i [*3];
  endsequence
  sequence s_loop_off;
    !fll_enable_o [*3];
  endsequence

  chk_reset_mode: assert property ($fell(sys_rst_i) |-> mode_o == MODE_LOOP_ENGAGED_INTERNAL
    && fll_ref_internal_o && trim_o == TRIM_RESET) else $error("bad state after reset");
  chk_trim_follow: assert property (!$past(sys_rst_i) |-> trim_o == $past(ctrl_i.trim))
    else $error("trim not followed");
  chk_osc_copy: assert property (!$past(sys_rst_i) |->
    osc_o.high_gain_select == $past(ctrl_i.high_gain_select) && osc_o.freq_range == $past(ctrl_i.freq_range)
    && osc_o.external_ref_select == $past(ctrl_i.external_ref_select)) else $error("oscillator lines wrong");
  chk_loop_enable: assert property ((fll_enable_o == !(mode_o inside
    {MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER, MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER}))
    && (fll_enable_o || $past(ctrl_i.low_power_bit) && !$past(debug_mode_i))) else $error("loop enable wrong");
  chk_stop_static: assert property (s_stop_held |-> $stable(output_clock_o) && $stable(debug_clock_o)
    && $stable(local_debug_clock_o) && $stable(fll_ref_clk_o)) else $error("clock moved in stop");
  chk_irc_gate: assert property (!$past(ctrl_i.internal_ref_clock_enable) ||
    $past(stop_i) && !$past(ctrl_i.internal_ref_stop_enable) |-> !internal_reference_clock_out_o)
    else $error("internal reference out not gated");
  chk_ext_gate: assert property (!$past(ctrl_i.external_ref_clock_enable) ||
    $past(stop_i) && !$past(ctrl_i.external_ref_stop_enable) |-> !external_reference_clock_out_o)
    else $error("external reference out not gated");
  chk_debug_hold: assert property (s_loop_off |-> $stable(debug_clock_o) && $stable(local_debug_clock_o))
    else $error("debug clock runs with loop off");
  chk_pend_mode: assert property (switch_pending_o && $past(switch_pending_o) |-> $stable(mode_o))
    else $error("mode changed while switch pending");
  chk_lowpwr_entry: assert property ($rose(mode_o == MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER) |->
    $past(ctrl_i.low_power_bit) && !$past(ctrl_i.internal_ref_select) && !$past(debug_mode_i)
    && $past(ctrl_i.clock_source_select) == CLOCK_SOURCE_SELECT_EXT) else $error("low power entry without its conditions");
  chk_relock_wait: assert property ($changed(fll_ref_internal_o) |->
    $past(ctrl_i.internal_ref_select, 4) == fll_ref_internal_o) else $error("loop reference switched early");
endmodule

bind fcs_top fcs_checker u_chk (.clock_i, .sys_rst_i, .ctrl_i, .debug_mode_i, .stop_i, .output_clock_o,
  .debug_clock_o, .local_debug_clock_o, .internal_reference_clock_out_o, .external_reference_clock_out_o,
  .fll_enable_o, .fll_ref_internal_o, .fll_ref_clk_o, .trim_o, .osc_o, .mode_o, .switch_pending_o);

// ==== fcs_div.sv ====
// Power-of-two clock divider working on sampled clock edges
module fcs_div #(
  parameter int unsigned CNT_W = 4,
  parameter int unsigned SEL_W = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Source clock as sampled level and its rising edge
  input wire logic src_lvl_i,
  input wire logic src_rise_i,
  // Divide by two to the power sel; run low freezes the output
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic run_i,
  output logic clk_o
);

  logic [CNT_W-1:0] cnt_q;
  logic clk_q;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else if (run_i && src_rise_i) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Ratio follows sel at once, no resync of the count
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      clk_q <= 1'b0;
    end else if (run_i) begin
      if (sel_i == '0) begin
        clk_q <= src_lvl_i;
      end else begin
        clk_q <= cnt_q[sel_i - SEL_W'(1)];
      end
    end
  end

  assign clk_o = clk_q;

endmodule

// ==== fcs_pkg.sv ====
// Shared constants, types and carriers of the clock source mode control
package fcs_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10000000;
  // Silence on a source longer than this marks it as stopped
  localparam int unsigned SRC_IDLE_NS = 100000;
  localparam int unsigned SRC_IDLE_CYC = (SRC_IDLE_NS / 1000) * (CLK_HZ / 1000000);
  localparam int unsigned IDLE_W = 11;
  localparam logic [IDLE_W-1:0] IDLE_LIMIT = IDLE_W'(SRC_IDLE_CYC);
  // Full cycles of a new clock seen before the switch is made
  localparam logic [2:0] SWITCH_EDGES = 3'h4;
  // Full cycles of the new divided reference before relock starts
  localparam logic [2:0] RELOCK_EDGES = 3'h3;

  // ---------------------------------------------------------------
  // Widths and encodings
  // ---------------------------------------------------------------
  localparam int unsigned TRIM_W = 9;
  localparam int unsigned REFERENCE_DIVIDER_W = 3;
  localparam int unsigned BUS_DIVIDER_W = 2;
  localparam int unsigned REF_CNT_W = 8;
  localparam int unsigned BUS_CNT_W = 4;
  localparam int unsigned NSRC = 3;
  localparam int unsigned SRC_IRC = 0;
  localparam int unsigned SRC_EXT = 1;
  localparam int unsigned SRC_DCO = 2;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_FLL = 2'h0;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_INT = 2'h1;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_EXT = 2'h2;
  localparam logic [BUS_DIVIDER_W-1:0] DEBUG_DIV_SEL = 2'h1;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 9'h100;

  typedef enum logic [1:0] {
    SEL_FLL,
    SEL_INT,
    SEL_EXT
  } fcs_src_t;

  typedef enum logic [2:0] {
    MODE_LOOP_ENGAGED_INTERNAL,
    MODE_LOOP_ENGAGED_EXTERNAL,
    MODE_LOOP_BYPASSED_INTERNAL,
    MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER,
    MODE_LOOP_BYPASSED_EXTERNAL,
    MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER
  } fcs_mode_t;

  typedef struct packed {
    logic [1:0] clock_source_select;
    logic internal_ref_select;
    logic low_power_bit;
    logic [REFERENCE_DIVIDER_W-1:0] reference_divider;
    logic [BUS_DIVIDER_W-1:0] bus_divider;
    logic [TRIM_W-1:0] trim;
    logic internal_ref_clock_enable;
    logic internal_ref_stop_enable;
    logic external_ref_clock_enable;
    logic external_ref_stop_enable;
    logic external_ref_select;
    logic high_gain_select;
    logic freq_range;
  } fcs_ctrl_t;

  typedef struct packed {
    logic high_gain_select;
    logic freq_range;
    logic external_ref_select;
    logic external_ref_clock_enable;
    logic external_ref_stop_enable;
    logic osc_enable;
  } fcs_osc_t;

endpackage

// ==== fcs_src_model.sv ====
// Behavioural raw clock sources seen by the block
module fcs_src_model (
  // Run controls
  input wire logic irc_run_i,
  input wire logic ext_run_i,
  input wire logic fll_enable_i,
  // Raw clocks
  output logic irc_clk_o,
  output logic ext_clk_o,
  output logic dco_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A stopped oscillator rests low, so a missing source shows no edges
  // Offset keeps every toggle clear of the sampling edge
  initial begin
    irc_clk_o = 1'b0;
    #20;
    forever #700 irc_clk_o = irc_run_i ? ~irc_clk_o : 1'b0;
  end
  initial begin
    ext_clk_o = 1'b0;
    #20;
    forever #450 ext_clk_o = ext_run_i ? ~ext_clk_o : 1'b0;
  end
  // Loop oscillator dies with the loop, as the real one would
  initial begin
    dco_clk_o = 1'b0;
    #20;
    forever #250 dco_clk_o = fll_enable_i ? ~dco_clk_o : 1'b0;
  end
endmodule

// ==== fcs_sync.sv ====
// Two flip-flop synchroniser for a group of levels
module fcs_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_o = sync_q;

endmodule

// ==== fcs_top.sv ====
// Mode, source selection and dividers of the FLL based clock source unit
//
// What this block does
// - Reset lands in loop engaged internal mode
// - Three-bit divider scales chosen reference for loop
// - Nine writable trim bits for internal oscillator
// - Bus divider gives ratios one, two, four, eight
// - Debug clock is oscillator divided by two
// - Engaged internal: loop on internal reference
// - Engaged external: loop on external reference
// - Bypassed internal: loop runs, output from reference
// - Bypassed internal low power: loop off, no debug
// - External low power needs 10, 0, no debug, one
// - External low power: loop off, external enabled
// - Stop freezes all clock outputs except kept ones
// - Internal reference out in stop needs both enables
// - External reference out in stop needs both enables
// - Relock waits some new divided reference cycles
// - Source switch waits some new clock cycles
// - Missing new source keeps previous source
// - Bus divider change acts at once
// - Drives control lines of external oscillator
module fcs_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Software control and system state
  input wire fcs_pkg::fcs_ctrl_t ctrl_i,
  input wire logic debug_mode_i,
  input wire logic stop_i,
  // Raw clocks from the analog side
  input wire logic irc_clk_i,
  input wire logic ext_clk_i,
  input wire logic dco_clk_i,
  // Clock outputs
  output logic output_clock_o,
  output logic debug_clock_o,
  output logic local_debug_clock_o,
  output logic internal_reference_clock_out_o,
  output logic external_reference_clock_out_o,
  // Loop and oscillator control
  output logic fll_enable_o,
  output logic fll_ref_internal_o,
  output logic fll_ref_clk_o,
  output logic [fcs_pkg::TRIM_W-1:0] trim_o,
  output fcs_pkg::fcs_osc_t osc_o,
  // Status
  output fcs_pkg::fcs_mode_t mode_o,
  output logic switch_pending_o
);
  import fcs_pkg::*;

  // ---------------------------------------------------------------
  // Source sampling and activity
  // ---------------------------------------------------------------
  logic [NSRC-1:0] src_raw;
  logic [NSRC-1:0] src_s;
  logic [NSRC-1:0] src_prev_q;
  logic [NSRC-1:0] src_rise;
  logic [NSRC-1:0] src_alive;
  logic [NSRC-1:0][IDLE_W-1:0] idle_q;

  assign src_raw[SRC_IRC] = irc_clk_i;
  assign src_raw[SRC_EXT] = ext_clk_i;
  assign src_raw[SRC_DCO] = dco_clk_i;

  fcs_sync #(
    .W(NSRC)
  ) u_src_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i(src_raw),
    .sync_o(src_s)
  );

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      src_prev_q <= '0;
    end else begin
      src_prev_q <= src_s;
    end
  end

  assign src_rise = src_s & ~src_prev_q;

  // A source counts as running while edges keep arriving
  for (genvar i = 0; i < NSRC; i++) begin : g_alive
    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        idle_q[i] <= IDLE_LIMIT;
      end else if (src_rise[i]) begin
        idle_q[i] <= '0;
      end else if (idle_q[i] != IDLE_LIMIT) begin
        idle_q[i] <= idle_q[i] + IDLE_W'(1);
      end
    end
    assign src_alive[i] = (idle_q[i] != IDLE_LIMIT);
  end

  // ---------------------------------------------------------------
  // Source switching
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT
  } fcs_sw_state_t;

  fcs_sw_state_t sw_q;
  fcs_src_t act_src_q;
  fcs_src_t req_src;
  fcs_src_t pend_src_q;
  logic [2:0] sw_cnt_q;
  logic req_rise;
  logic req_alive;

  always_comb begin
    case (ctrl_i.clock_source_select)
      CLOCK_SOURCE_SELECT_FLL: req_src = SEL_FLL;
      CLOCK_SOURCE_SELECT_INT: req_src = SEL_INT;
      CLOCK_SOURCE_SELECT_EXT: req_src = SEL_EXT;
      // Reserved code leaves the active source alone
      default: req_src = act_src_q;
    endcase
  end

  always_comb begin
    case (req_src)
      SEL_INT: begin
        req_rise = src_rise[SRC_IRC];
        req_alive = src_alive[SRC_IRC];
      end
      SEL_EXT: begin
        req_rise = src_rise[SRC_EXT];
        req_alive = src_alive[SRC_EXT];
      end
      default: begin
        req_rise = src_rise[SRC_DCO];
        req_alive = src_alive[SRC_DCO];
      end
    endcase
  end

  // Commit only after full cycles of the new clock; a dead one never commits
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sw_q <= SW_IDLE;
      act_src_q <= SEL_FLL;
      pend_src_q <= SEL_FLL;
      sw_cnt_q <= '0;
    end else begin
      case (sw_q)
        SW_IDLE: begin
          if (req_src != act_src_q) begin
            sw_q <= SW_WAIT;
            pend_src_q <= req_src;
            sw_cnt_q <= '0;
          end
        end
        SW_WAIT: begin
          if (req_src == act_src_q) begin
            sw_q <= SW_IDLE;
          end else if (req_src != pend_src_q) begin
            pend_src_q <= req_src;
            sw_cnt_q <= '0;
          end else if (!req_alive) begin
            sw_cnt_q <= '0;
          end else if (req_rise) begin
            if (sw_cnt_q == SWITCH_EDGES) begin
              act_src_q <= pend_src_q;
              sw_q <= SW_IDLE;
            end else begin
              sw_cnt_q <= sw_cnt_q + 3'h1;
            end
          end
        end
        default: sw_q <= SW_IDLE;
      endcase
    end
  end

  assign switch_pending_o = (sw_q == SW_WAIT);

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  fcs_mode_t mode_d;
  fcs_mode_t mode_q;
  logic fll_ref_int_q;
  logic low_power_ok;

  assign low_power_ok = ctrl_i.low_power_bit && !debug_mode_i;

  always_comb begin
    case (act_src_q)
      SEL_INT: begin
        if (low_power_ok) begin
          mode_d = MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER;
        end else begin
          mode_d = MODE_LOOP_BYPASSED_INTERNAL;
        end
      end
      SEL_EXT: begin
        if (low_power_ok && !ctrl_i.internal_ref_select) begin
          mode_d = MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER;
        end else begin
          mode_d = MODE_LOOP_BYPASSED_EXTERNAL;
        end
      end
      default: begin
        if (fll_ref_int_q) begin
          mode_d = MODE_LOOP_ENGAGED_INTERNAL;
        end else begin
          mode_d = MODE_LOOP_ENGAGED_EXTERNAL;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mode_q <= MODE_LOOP_ENGAGED_INTERNAL;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign mode_o = mode_q;

  logic fll_on;

  assign fll_on = (mode_q != MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER) &&
                  (mode_q != MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER);

  // ---------------------------------------------------------------
  // Reference dividers and relock
  // ---------------------------------------------------------------
  logic irc_div;
  logic ext_div;
  logic irc_div_prev_q;
  logic ext_div_prev_q;
  logic new_ref_rise;
  logic [2:0] relock_cnt_q;

  // Both references are divided so the new one is ready at a swap
  fcs_div #(
    .CNT_W(REF_CNT_W),
    .SEL_W(REFERENCE_DIVIDER_W)
  ) u_irc_div (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .src_lvl_i(src_s[SRC_IRC]),
    .src_rise_i(src_rise[SRC_IRC]),
    .sel_i(ctrl_i.reference_divider),
    .run_i(!stop_i),
    .clk_o(irc_div)
  );

  fcs_div #(
    .CNT_W(REF_CNT_W),
    .SEL_W(REFERENCE_DIVIDER_W)
  ) u_ext_div (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .src_lvl_i(src_s[SRC_EXT]),
    .src_rise_i(src_rise[SRC_EXT]),
    .sel_i(ctrl_i.reference_divider),
    .run_i(!stop_i),
    .clk_o(ext_div)
  );

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irc_div_prev_q <= 1'b0;
      ext_div_prev_q <= 1'b0;
    end else begin
      irc_div_prev_q <= irc_div;
      ext_div_prev_q <= ext_div;
    end
  end

  assign new_ref_rise = ctrl_i.internal_ref_select ? (irc_div && !irc_div_prev_q)
                                                   : (ext_div && !ext_div_prev_q);

  // Loop keeps its old reference until the new one has shown full cycles
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      fll_ref_int_q <= 1'b1;
      relock_cnt_q <= '0;
    end else if (ctrl_i.internal_ref_select == fll_ref_int_q) begin
      relock_cnt_q <= '0;
    end else if (new_ref_rise) begin
      if (relock_cnt_q == RELOCK_EDGES) begin
        fll_ref_int_q <= ctrl_i.internal_ref_select;
        relock_cnt_q <= '0;
      end else begin
        relock_cnt_q <= relock_cnt_q + 3'h1;
      end
    end
  end

  logic fll_ref_clk_q;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      fll_ref_clk_q <= 1'b0;
    end else if (!stop_i && fll_on) begin
      fll_ref_clk_q <= fll_ref_int_q ? irc_div : ext_div;
    end
  end

  assign fll_ref_clk_o = fll_ref_clk_q;
  assign fll_enable_o = fll_on;
  assign fll_ref_internal_o = fll_ref_int_q;

  // ---------------------------------------------------------------
  // Output and debug clocks
  // ---------------------------------------------------------------
  logic sel_lvl;
  logic sel_rise;

  always_comb begin
    case (act_src_q)
      SEL_INT: begin
        sel_lvl = src_s[SRC_IRC];
        sel_rise = src_rise[SRC_IRC];
      end
      SEL_EXT: begin
        sel_lvl = src_s[SRC_EXT];
        sel_rise = src_rise[SRC_EXT];
      end
      default: begin
        sel_lvl = src_s[SRC_DCO];
        sel_rise = src_rise[SRC_DCO];
      end
    endcase
  end

  // Ratio is read straight from the control bits, no handover wait
  fcs_div #(
    .CNT_W(BUS_CNT_W),
    .SEL_W(BUS_DIVIDER_W)
  ) u_bus_div (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .src_lvl_i(sel_lvl),
    .src_rise_i(sel_rise),
    .sel_i(ctrl_i.bus_divider),
    .run_i(!stop_i),
    .clk_o(output_clock_o)
  );

  logic dbg_clk;
  logic lcl_clk_q;

  fcs_div #(
    .CNT_W(BUS_CNT_W),
    .SEL_W(BUS_DIVIDER_W)
  ) u_dbg_div (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .src_lvl_i(src_s[SRC_DCO]),
    .src_rise_i(src_rise[SRC_DCO]),
    .sel_i(DEBUG_DIV_SEL),
    .run_i(!stop_i && fll_on),
    .clk_o(dbg_clk)
  );

  assign debug_clock_o = dbg_clk;

  // Local debug clock goes quiet with the loop
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      lcl_clk_q <= 1'b0;
    end else if (!stop_i && fll_on) begin
      lcl_clk_q <= dbg_clk;
    end
  end

  assign local_debug_clock_o = lcl_clk_q;

  // ---------------------------------------------------------------
  // Reference clock outputs
  // ---------------------------------------------------------------
  logic irc_out_q;
  logic ext_out_q;
  logic irc_run;
  logic ext_run;

  assign irc_run = ctrl_i.internal_ref_clock_enable &&
                   (!stop_i || ctrl_i.internal_ref_stop_enable);
  assign ext_run = ctrl_i.external_ref_clock_enable &&
                   (!stop_i || ctrl_i.external_ref_stop_enable);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irc_out_q <= 1'b0;
    end else if (irc_run) begin
      irc_out_q <= src_s[SRC_IRC];
    end else begin
      irc_out_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ext_out_q <= 1'b0;
    end else if (ext_run) begin
      ext_out_q <= src_s[SRC_EXT];
    end else begin
      ext_out_q <= 1'b0;
    end
  end

  assign internal_reference_clock_out_o = irc_out_q;
  assign external_reference_clock_out_o = ext_out_q;

  // ---------------------------------------------------------------
  // Trim and oscillator control
  // ---------------------------------------------------------------
  logic [TRIM_W-1:0] trim_q;
  fcs_osc_t osc_q;
  logic ext_needed;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      trim_q <= TRIM_RESET;
    end else begin
      trim_q <= ctrl_i.trim;
    end
  end

  assign trim_o = trim_q;

  // Oscillator stays on whenever anything still uses the external reference
  assign ext_needed = (act_src_q == SEL_EXT) || (fll_on && !fll_ref_int_q) ||
                      (!ctrl_i.internal_ref_select) || ext_run;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      osc_q <= '0;
    end else begin
      osc_q.high_gain_select <= ctrl_i.high_gain_select;
      osc_q.freq_range <= ctrl_i.freq_range;
      osc_q.external_ref_select <= ctrl_i.external_ref_select;
      osc_q.external_ref_clock_enable <= ctrl_i.external_ref_clock_enable;
      osc_q.external_ref_stop_enable <= ctrl_i.external_ref_stop_enable;
      osc_q.osc_enable <= ext_needed && (!stop_i || ext_run);
    end
  end

  assign osc_o = osc_q;

endmodule

// ==== fcs_top_bench.sv ====
// Self-checking bench for the clock source mode control
module fcs_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import fcs_pkg::*;
  logic clock_i, sys_rst_i, debug_mode_i, stop_i, irc_run, ext_run;
  logic irc_clk, ext_clk, dco_clk, out_clk, dbg_clk, irc_out, ext_out, fll_en, ref_int, pend, lcl_clk, ref_clk;
  logic [TRIM_W-1:0] trim;
  fcs_ctrl_t ctrl;
  fcs_osc_t osc;
  fcs_mode_t mode;
  int fail_count = 0;
  int tests_run = 0;
  int c[6];

  fcs_src_model u_src (.irc_run_i(irc_run), .ext_run_i(ext_run), .fll_enable_i(fll_en),
    .irc_clk_o(irc_clk), .ext_clk_o(ext_clk), .dco_clk_o(dco_clk));
  fcs_top u_dut (.clock_i, .sys_rst_i, .ctrl_i(ctrl), .debug_mode_i, .stop_i, .irc_clk_i(irc_clk),
    .ext_clk_i(ext_clk), .dco_clk_i(dco_clk), .output_clock_o(out_clk), .debug_clock_o(dbg_clk),
    .local_debug_clock_o(lcl_clk), .internal_reference_clock_out_o(irc_out),
    .external_reference_clock_out_o(ext_out), .fll_enable_o(fll_en), .fll_ref_internal_o(ref_int),
    .fll_ref_clk_o(ref_clk), .trim_o(trim), .osc_o(osc), .mode_o(mode), .switch_pending_o(pend));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Edge counts drift by a cycle or two through the synchronisers
  task automatic near(input int got, input int exp);
    chk(16'(got >= exp - 2 && got <= exp + 2), 16'h1);
  endtask
  task automatic count(input int n);
    logic [5:0] v, p;
    c = '{0, 0, 0, 0, 0, 0};
    p = {out_clk, dbg_clk, irc_out, ext_out, lcl_clk, ref_clk};
    repeat (n) begin
      @(negedge clock_i);
      v = {out_clk, dbg_clk, irc_out, ext_out, lcl_clk, ref_clk};
      for (int i = 0; i < 6; i++) c[i] += int'(v[5-i] & ~p[5-i]);
      p = v;
    end
  endtask
  task automatic wait_mode(input fcs_mode_t m, input int lim);
    for (int k = 0; k < lim && mode !== m; k++) @(negedge clock_i);
    chk(16'(mode), 16'(m));
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk(16'(mode), 16'(MODE_LOOP_ENGAGED_INTERNAL));
    chk(16'({ref_int, fll_en, pend}), 16'h6);
    chk(16'(trim), 16'(TRIM_RESET));
    chk(16'(osc), 16'h0);
  endtask
  task automatic t_ctrl();
    ctrl.trim = 9'h0a5;
    ctrl.high_gain_select = 1'b1;
    ctrl.freq_range = 1'b1;
    ctrl.external_ref_select = 1'b1;
    repeat (2) @(negedge clock_i);
    chk(16'(trim), 16'h00a5);
    chk(16'({osc.high_gain_select, osc.freq_range, osc.external_ref_select}), 16'h7);
  endtask
  task automatic t_bus_divider();
    for (int d = 0; d < 4; d++) begin
      ctrl.bus_divider = 2'(d);
      ctrl.reference_divider = 3'(d);
      count(400);
      near(c[0], 80 >> d);
      near(c[1], 40);
      near(c[4], 40);
      near(c[5], 29 >> d);
    end
    ctrl.bus_divider = 2'h0;
    ctrl.reference_divider = 3'h0;
  endtask
  task automatic t_switch();
    ctrl.clock_source_select = CLOCK_SOURCE_SELECT_INT;
    repeat (2) @(negedge clock_i);
    chk(16'({pend, mode}), {13'h1, 3'(MODE_LOOP_ENGAGED_INTERNAL)});
    wait_mode(MODE_LOOP_BYPASSED_INTERNAL, 200);
    count(300);
    near(c[0], 21);
    near(c[1], 30);
    ctrl.low_power_bit = 1'b1;
    wait_mode(MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER, 20);
    count(100);
    chk(16'({fll_en, 8'(c[1])}), 16'h0);
    chk(16'({8'(c[4]), 8'(c[5])}), 16'h0);
  endtask
  task automatic t_ext();
    ctrl.clock_source_select = CLOCK_SOURCE_SELECT_EXT;
    ctrl.internal_ref_select = 1'b0;
    ctrl.reference_divider = 3'h0;
    repeat (1200) @(negedge clock_i);
    chk(16'({pend, mode}), {13'h1, 3'(MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER)});
    ext_run = 1'b1;
    wait_mode(MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER, 200);
    count(100);
    chk(16'({fll_en, osc.osc_enable, 8'(c[1])}), 16'h100);
    chk(16'({8'(c[4]), 8'(c[5])}), 16'h0);
    near(c[0], 11);
    debug_mode_i = 1'b1;
    wait_mode(MODE_LOOP_BYPASSED_EXTERNAL, 20);
    debug_mode_i = 1'b0;
    ctrl.low_power_bit = 1'b0;
  endtask
  task automatic t_ref();
    ctrl.clock_source_select = CLOCK_SOURCE_SELECT_FLL;
    wait_mode(MODE_LOOP_ENGAGED_EXTERNAL, 200);
    chk(16'(ref_int), 16'h0);
    ctrl.internal_ref_select = 1'b1;
    repeat (2) @(negedge clock_i);
    chk(16'(ref_int), 16'h0);
    for (int k = 0; k < 150 && ref_int !== 1'b1; k++) @(negedge clock_i);
    chk(16'(ref_int), 16'h1);
    wait_mode(MODE_LOOP_ENGAGED_INTERNAL, 50);
  endtask
  task automatic t_stop();
    ctrl.internal_ref_clock_enable = 1'b1;
    ctrl.internal_ref_stop_enable = 1'b1;
    ctrl.external_ref_clock_enable = 1'b1;
    stop_i = 1'b1;
    repeat (5) @(negedge clock_i);
    count(300);
    chk(16'({8'(c[0]), 8'(c[1])}), 16'h0);
    chk(16'({8'(c[4]), 8'(c[5])}), 16'h0);
    chk(16'({c[2] > 0, c[3] > 0}), 16'h2);
    ctrl.internal_ref_stop_enable = 1'b0;
    ctrl.external_ref_stop_enable = 1'b1;
    repeat (5) @(negedge clock_i);
    count(300);
    chk(16'({c[2] > 0, c[3] > 0}), 16'h1);
    stop_i = 1'b0;
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // About 4100 cycles are expected; allow nearly five times that
  initial begin
    #2000000;
    fail_count++;
    end_of_test();
  end
  initial begin
    ctrl = '0;
    ctrl.internal_ref_select = 1'b1;
    sys_rst_i = 1'b1;
    debug_mode_i = 1'b0;
    stop_i = 1'b0;
    irc_run = 1'b1;
    ext_run = 1'b0;
    repeat (10) @(negedge clock_i);
    sys_rst_i = 1'b0;
    t_reset();
    @(negedge clock_i);
    t_ctrl();
    t_bus_divider();
    t_switch();
    t_ext();
    t_ref();
    t_stop();
    end_of_test();
  end
endmodule
